//--- hw/dda_pkg.sv
package dda_pkg;
  localparam int ADDR_W = 8;
  localparam int EXT_W = 4;
  localparam int FL_W = 5;
  localparam int COND_W = 8;
  localparam int OP_W = 5;
  // Accumulator field positions
  localparam int SB = 35;
  localparam int EL = 32;
  localparam int UH = 31;
  localparam int UL = 16;
  localparam int LH = 15;
  localparam logic [2:0] HSIZE_WORD = 3'h2;
  localparam int HTRANS_ACT_BIT = 1;
  // Register byte offsets
  localparam logic [7:0] OFS_MODE = 8'h00;
  localparam logic [7:0] OFS_OPX = 8'h04;
  localparam logic [7:0] OFS_OPY = 8'h08;
  localparam logic [7:0] OFS_CMD = 8'h0C;
  localparam logic [7:0] OFS_FLAGS = 8'h10;
  localparam logic [7:0] OFS_COND = 8'h14;
  localparam logic [7:0] OFS_A_EXT = 8'h18;
  localparam logic [7:0] OFS_A_UP = 8'h1C;
  localparam logic [7:0] OFS_A_LO = 8'h20;
  localparam logic [7:0] OFS_B_EXT = 8'h24;
  localparam logic [7:0] OFS_B_UP = 8'h28;
  localparam logic [7:0] OFS_B_LO = 8'h2C;
  localparam logic [7:0] OFS_A_WORD = 8'h30;
  localparam logic [7:0] OFS_B_WORD = 8'h34;
  localparam logic [7:0] OFS_A_LIM = 8'h38;
  localparam logic [7:0] OFS_B_LIM = 8'h3C;
  localparam int MODE_UCMP_BIT = 0;
  localparam int CMD_OP_LSB = 0;
  localparam int CMD_DST_BIT = 8;
  localparam int CMD_PM_EN_BIT = 12;
  localparam int CMD_PM_DIR_BIT = 13;
  localparam int FL_C = 0;
  localparam int FL_V = 1;
  localparam int FL_Z = 2;
  localparam int FL_N = 3;
  localparam int FL_L = 4;
  localparam int CD_HS = 0;
  localparam int CD_LS = 1;
  localparam int CD_HI = 2;
  localparam int CD_LO = 3;
  localparam int CD_GE = 4;
  localparam int CD_LE = 5;
  localparam int CD_GT = 6;
  localparam int CD_LT = 7;
  localparam logic [35:0] ROUND_INC = 36'h0_0000_8000;
  localparam logic [35:0] WORD_ONE = 36'h0_0001_0000;
  localparam logic [15:0] WORD_POS_MAX = 16'h7FFF;
  localparam logic [15:0] WORD_NEG_MAX = 16'h8000;

  typedef enum logic [4:0] {
    OP_NOP, OP_ADD, OP_SUB, OP_CMP, OP_ADDACC, OP_SUBACC, OP_AND, OP_OR,
    OP_EOR, OP_BFCLR, OP_NOT, OP_LSL, OP_LSR, OP_ROL, OP_ROR, OP_ASL,
    OP_ASR, OP_WORD_INCREMENT, OP_WORD_DECREMENT, OP_MPY, OP_MAC, OP_ROUNDED_MULTIPLY, OP_ROUNDED_MULTIPLY_ACCUMULATE, OP_IMPY,
    OP_DIV
  } dda_op_t;

  typedef struct packed {
    logic [35:0] r;
    logic c36;
    logic c32;
    logic v36;
    logic v32;
  } dda_sum_t;

  typedef struct packed {
    logic mode;
    logic [15:0] opx;
    logic [15:0] opy;
    logic [1:0][35:0] acc;
    logic [4:0] flags;
    logic pend;
    logic wr;
    logic hit;
    logic [7:0] addr;
    logic rdy;
    logic [31:0] rdata;
    logic resp;
    logic h_ex;
    logic [4:0] h_op;
    logic h_dst;
    logic [35:0] h_dv;
    logic [15:0] h_x;
    logic h_ovf;
    logic h_mode;
  } dda_state_t;

  localparam dda_state_t ST_RST = '{rdy: 1'b1, default: '0};
endpackage : dda_pkg

//--- hw/dda_mul_if.sv
`timescale 1ns/10ps
interface dda_mul_if;
  logic [15:0] x;
  logic [15:0] y;
  logic [31:0] frac;
  logic [31:0] intp;
  logic ovf;
  modport alu (output x, output y, input frac, input intp, input ovf);
  modport mul (input x, input y, output frac, output intp, output ovf);
endinterface : dda_mul_if

//--- hw/dda_mul.sv
`timescale 1ns/10ps
module dda_mul (
  dda_mul_if.mul m // Operands in, formatted products out
);
  logic signed [31:0] p;

  assign p = $signed(m.x) * $signed(m.y);
  // Zero appended below the 31 product bits
  assign m.frac = {p[dda_pkg::UH-1:0], 1'b0};
  // Sign copied above the 31 product bits
  assign m.intp = {p[dda_pkg::UH], p[dda_pkg::UH-1:0]};
  // Word product valid only if bits above 15 are sign copies
  assign m.ovf = (p[dda_pkg::UH:dda_pkg::LH] !=
                  {(dda_pkg::UH - dda_pkg::LH + 1){p[dda_pkg::LH]}});
endmodule : dda_mul

//--- hw/dda_alu.sv
// Decided for this implementation: the AHB-Lite register port and the register offsets.
`timescale 1ns/10ps
// Behaviour
// - Add, subtract, compare are bit-identical for fractional and integer.
// - Word operands align to the upper word before word arithmetic.
// - AND, OR, XOR, bit-field ops ignore number format.
// - Left shift doubles; arith right keeps sign; logical right inserts 0.
// - Fractional product gets a zero appended at the LSB.
// - Integer product gets an extra sign bit at the MSB.
// - 16x16 fractional product is 32 bits, LSB zero, accumulates into 36.
// - Rounded multiply forms round to 16 bits and clear lower word.
// - Word integer multiply: product to bits 31-16, sign ext, lower kept.
// - Word integer multiply flags overflow when product exceeds 16 bits.
// - Word shifts, rotates, invert, increment, decrement use upper word.
// - Parallel moves reach the upper word both ways; a move into an accumulator clears its lower word.
// - Fractional multiply then arith right shift gives integer product.
// - Division step takes 32-bit dividend, 16-bit divisor, signed or not.
// - Four unsigned branch conditions mirror the four signed ones.
// - Unsigned at-least is carry clear; unsigned under is carry set.
// - Unsigned compare mode derives flags from low 32 result bits only; arith left shift and divide step still set C and V from extension bits.
// - Signed integers are two's complement, point right of LSB.
// - Unsigned fractional words have the point after the MSB.
// - Unsigned integer words range zero to 65535.
// - Values using the extension limit to the destination's extremes.
// - Word to accumulator: upper word, sign extended, lower cleared.
module dda_alu (
  input wire logic hclk, // Core clock
  input wire logic hresetn, // Async reset, active low
  input wire logic hsel, // Slave select
  input wire logic [31:0] haddr, // Byte address
  input wire logic [1:0] htrans, // Transfer type
  input wire logic hwrite, // Write when high
  input wire logic [2:0] hsize, // Transfer size
  input wire logic [31:0] hwdata, // Write data
  input wire logic hready, // Bus ready
  output logic hreadyout, // Slave ready
  output logic [31:0] hrdata, // Read data
  output logic hresp // Always OKAY
);
  localparam int SB = dda_pkg::SB;
  localparam int EL = dda_pkg::EL;
  localparam int UH = dda_pkg::UH;
  localparam int UL = dda_pkg::UL;
  localparam int LH = dda_pkg::LH;
  localparam int EW = dda_pkg::EXT_W;

  dda_pkg::dda_state_t q;
  dda_pkg::dda_state_t d;
  dda_mul_if mi ();
  logic exec;
  dda_pkg::dda_op_t ex_op;
  logic ex_dst;
  logic [35:0] ex_dv;
  logic [35:0] ex_ov;
  logic [35:0] ex_xw;
  logic [35:0] hx_w;
  logic [7:0] cond;
  logic [15:0] lim_a;
  logic [15:0] lim_b;

  function automatic logic [35:0] word_load(input logic [15:0] w);
    return {{EW{w[LH]}}, w, 16'h0000};
  endfunction : word_load

  function automatic logic [15:0] lim16(input logic [35:0] a);
    if (a[SB:UH] == {(SB - UH + 1){a[SB]}}) begin
      return a[UH:UL];
    end
    return a[SB] ? dda_pkg::WORD_NEG_MAX : dda_pkg::WORD_POS_MAX;
  endfunction : lim16

  function automatic logic [35:0] rnd(input logic [35:0] a);
    logic [35:0] s;
    s = a + dda_pkg::ROUND_INC;
    return {s[SB:UL], 16'h0000};
  endfunction : rnd

  function automatic dda_pkg::dda_sum_t add36(input logic [35:0] a,
                                             input logic [35:0] b,
                                             input logic sub);
    dda_pkg::dda_sum_t s;
    logic [36:0] t;
    logic [32:0] l;
    logic [35:0] bb;
    bb = sub ? ~b : b;
    t = {1'b0, a} + {1'b0, bb} + {36'h0, sub};
    l = {1'b0, a[UH:0]} + {1'b0, bb[UH:0]} + {32'h0, sub};
    s.r = t[SB:0];
    // Carry reads as borrow on subtract
    s.c36 = t[SB+1] ^ sub;
    s.c32 = l[UH+1] ^ sub;
    s.v36 = (a[SB] == bb[SB]) && (t[SB] != a[SB]);
    s.v32 = (a[UH] == bb[UH]) && (l[UH] != a[UH]);
    return s;
  endfunction : add36

  function automatic logic [1:0] cv(input dda_pkg::dda_sum_t s,
                                    input logic um);
    // Low 32 bits only in unsigned compare mode
    return um ? {s.c32, s.v32} : {s.c36, s.v36};
  endfunction : cv

  dda_mul u_mul (
    .m(mi.mul)
  );

  assign mi.x = q.opx;
  assign mi.y = q.opy;
  assign exec = q.pend & q.wr & q.hit & (q.addr == dda_pkg::OFS_CMD);
  assign ex_op = dda_pkg::dda_op_t'(hwdata[dda_pkg::CMD_OP_LSB +:
                                           dda_pkg::OP_W]);
  assign ex_dst = hwdata[dda_pkg::CMD_DST_BIT];
  assign ex_dv = q.acc[ex_dst];
  assign ex_ov = q.acc[~ex_dst];
  assign ex_xw = word_load(q.opx);
  assign hx_w = word_load(q.h_x);
  assign lim_a = lim16(q.acc[0]);
  assign lim_b = lim16(q.acc[1]);

  // Unsigned conditions from carry and zero
  assign cond[dda_pkg::CD_HS] = ~q.flags[dda_pkg::FL_C];
  assign cond[dda_pkg::CD_LO] = q.flags[dda_pkg::FL_C];
  assign cond[dda_pkg::CD_HI] = ~q.flags[dda_pkg::FL_C] &
                                ~q.flags[dda_pkg::FL_Z];
  assign cond[dda_pkg::CD_LS] = q.flags[dda_pkg::FL_C] |
                                q.flags[dda_pkg::FL_Z];
  // Signed conditions from negative, overflow and zero
  assign cond[dda_pkg::CD_GE] = ~(q.flags[dda_pkg::FL_N] ^
                                  q.flags[dda_pkg::FL_V]);
  assign cond[dda_pkg::CD_LT] = q.flags[dda_pkg::FL_N] ^
                                q.flags[dda_pkg::FL_V];
  assign cond[dda_pkg::CD_GT] = ~q.flags[dda_pkg::FL_Z] &
                                cond[dda_pkg::CD_GE];
  assign cond[dda_pkg::CD_LE] = q.flags[dda_pkg::FL_Z] |
                                cond[dda_pkg::CD_LT];

  always_comb begin
    logic [35:0] t;
    logic [31:0] rd;
    logic [15:0] w;
    logic c;
    logic v;
    logic wacc;
    logic [4:0] fl;
    dda_pkg::dda_sum_t sm;
    t = {{EW{mi.frac[UH]}}, mi.frac};
    rd = 32'h0;
    w = 16'h0;
    c = q.flags[dda_pkg::FL_C];
    v = 1'b0;
    wacc = 1'b1;
    fl = q.flags;
    sm = '{r: ex_dv, default: 1'b0};
    d = q;
    d.rdy = 1'b1;
    d.resp = 1'b0;
    d.h_ex = 1'b0;
    d.h_op = ex_op;
    d.h_dst = ex_dst;
    d.h_dv = ex_dv;
    d.h_x = q.opx;
    d.h_ovf = mi.ovf;
    d.h_mode = q.mode;
    if (q.pend) begin
      d.pend = 1'b0;
      if (!q.wr) begin
        if (!q.hit) begin
          rd = 32'h0;
        end else if (q.addr == dda_pkg::OFS_MODE) begin
          rd = {31'h0, q.mode};
        end else if (q.addr == dda_pkg::OFS_OPX) begin
          rd = {16'h0, q.opx};
        end else if (q.addr == dda_pkg::OFS_OPY) begin
          rd = {16'h0, q.opy};
        end else if (q.addr == dda_pkg::OFS_FLAGS) begin
          rd = {27'h0, q.flags};
        end else if (q.addr == dda_pkg::OFS_COND) begin
          rd = {24'h0, cond};
        end else if (q.addr == dda_pkg::OFS_A_EXT) begin
          rd = {28'h0, q.acc[0][SB:EL]};
        end else if (q.addr == dda_pkg::OFS_A_UP) begin
          rd = {16'h0, q.acc[0][UH:UL]};
        end else if (q.addr == dda_pkg::OFS_A_LO) begin
          rd = {16'h0, q.acc[0][LH:0]};
        end else if (q.addr == dda_pkg::OFS_B_EXT) begin
          rd = {28'h0, q.acc[1][SB:EL]};
        end else if (q.addr == dda_pkg::OFS_B_UP) begin
          rd = {16'h0, q.acc[1][UH:UL]};
        end else if (q.addr == dda_pkg::OFS_B_LO) begin
          rd = {16'h0, q.acc[1][LH:0]};
        end else if (q.addr == dda_pkg::OFS_A_LIM) begin
          rd = {16'h0, lim_a};
        end else if (q.addr == dda_pkg::OFS_B_LIM) begin
          rd = {16'h0, lim_b};
        end
        d.rdata = rd;
      end else if (!q.hit) begin
        d.rdata = q.rdata;
      end else if (q.addr == dda_pkg::OFS_MODE) begin
        d.mode = hwdata[dda_pkg::MODE_UCMP_BIT];
      end else if (q.addr == dda_pkg::OFS_OPX) begin
        d.opx = hwdata[LH:0];
      end else if (q.addr == dda_pkg::OFS_OPY) begin
        d.opy = hwdata[LH:0];
      end else if (q.addr == dda_pkg::OFS_A_EXT) begin
        d.acc[0][SB:EL] = hwdata[EW-1:0];
      end else if (q.addr == dda_pkg::OFS_A_UP) begin
        d.acc[0][UH:UL] = hwdata[LH:0];
      end else if (q.addr == dda_pkg::OFS_A_LO) begin
        d.acc[0][LH:0] = hwdata[LH:0];
      end else if (q.addr == dda_pkg::OFS_B_EXT) begin
        d.acc[1][SB:EL] = hwdata[EW-1:0];
      end else if (q.addr == dda_pkg::OFS_B_UP) begin
        d.acc[1][UH:UL] = hwdata[LH:0];
      end else if (q.addr == dda_pkg::OFS_B_LO) begin
        d.acc[1][LH:0] = hwdata[LH:0];
      end else if (q.addr == dda_pkg::OFS_A_WORD) begin
        d.acc[0] = word_load(hwdata[LH:0]);
      end else if (q.addr == dda_pkg::OFS_B_WORD) begin
        d.acc[1] = word_load(hwdata[LH:0]);
      end else if (exec) begin
        d.h_ex = 1'b1;
        case (ex_op)
          dda_pkg::OP_ADD, dda_pkg::OP_SUB, dda_pkg::OP_CMP: begin
            sm = add36(ex_dv, ex_xw, ex_op != dda_pkg::OP_ADD);
            {c, v} = cv(sm, q.mode);
            wacc = (ex_op != dda_pkg::OP_CMP);
          end
          dda_pkg::OP_ADDACC, dda_pkg::OP_SUBACC: begin
            sm = add36(ex_dv, ex_ov, ex_op == dda_pkg::OP_SUBACC);
            {c, v} = cv(sm, q.mode);
          end
          dda_pkg::OP_AND, dda_pkg::OP_OR, dda_pkg::OP_EOR,
          dda_pkg::OP_BFCLR, dda_pkg::OP_NOT: begin
            case (ex_op)
              dda_pkg::OP_AND: w = ex_dv[UH:UL] & q.opx;
              dda_pkg::OP_OR: w = ex_dv[UH:UL] | q.opx;
              dda_pkg::OP_EOR: w = ex_dv[UH:UL] ^ q.opx;
              dda_pkg::OP_BFCLR: w = ex_dv[UH:UL] & ~q.opx;
              default: w = ~ex_dv[UH:UL];
            endcase
            sm.r[UH:UL] = w;
          end
          dda_pkg::OP_LSL: begin
            sm.r[UH:UL] = {ex_dv[UH-1:UL], 1'b0};
            c = ex_dv[UH];
          end
          dda_pkg::OP_LSR: begin
            sm.r[UH:UL] = {1'b0, ex_dv[UH:UL+1]};
            c = ex_dv[UL];
          end
          dda_pkg::OP_ROL: begin
            sm.r[UH:UL] = {ex_dv[UH-1:UL], q.flags[dda_pkg::FL_C]};
            c = ex_dv[UH];
          end
          dda_pkg::OP_ROR: begin
            sm.r[UH:UL] = {q.flags[dda_pkg::FL_C], ex_dv[UH:UL+1]};
            c = ex_dv[UL];
          end
          dda_pkg::OP_ASL: begin
            sm.r = {ex_dv[SB-1:0], 1'b0};
            c = ex_dv[SB];
            v = ex_dv[SB] ^ ex_dv[SB-1];
          end
          dda_pkg::OP_ASR: begin
            // Whole accumulator, so a prior fraction becomes an integer
            sm.r = {ex_dv[SB], ex_dv[SB:1]};
            c = ex_dv[0];
          end
          dda_pkg::OP_WORD_INCREMENT, dda_pkg::OP_WORD_DECREMENT: begin
            sm = add36(ex_dv, dda_pkg::WORD_ONE,
                       ex_op == dda_pkg::OP_WORD_DECREMENT);
            {c, v} = cv(sm, q.mode);
          end
          dda_pkg::OP_MPY, dda_pkg::OP_ROUNDED_MULTIPLY: begin
            sm.r = (ex_op == dda_pkg::OP_ROUNDED_MULTIPLY) ? rnd(t) : t;
          end
          dda_pkg::OP_MAC, dda_pkg::OP_ROUNDED_MULTIPLY_ACCUMULATE: begin
            sm = add36(ex_dv, t, 1'b0);
            {c, v} = cv(sm, q.mode);
            if (ex_op == dda_pkg::OP_ROUNDED_MULTIPLY_ACCUMULATE) begin
              sm.r = rnd(sm.r);
            end
          end
          dda_pkg::OP_IMPY: begin
            sm.r = {{EW{mi.intp[LH]}}, mi.intp[LH:0], ex_dv[LH:0]};
            fl[dda_pkg::FL_L] = mi.ovf;
          end
          dda_pkg::OP_DIV: begin
            // Shift carry in, then add or subtract by sign agreement
            t = {ex_dv[SB-1:0], q.flags[dda_pkg::FL_C]};
            sm = add36(t, ex_xw, ~(ex_dv[SB] ^ q.opx[LH]));
            c = ~(sm.r[SB] ^ q.opx[LH]);
            v = ex_dv[SB] ^ ex_dv[SB-1];
          end
          default: begin
            wacc = 1'b0;
          end
        endcase
        fl[dda_pkg::FL_C] = c;
        fl[dda_pkg::FL_V] = v;
        fl[dda_pkg::FL_N] = q.mode ? sm.r[UH] : sm.r[SB];
        fl[dda_pkg::FL_Z] = q.mode ? (sm.r[UH:0] == 32'h0) :
                                     (sm.r == 36'h0);
        if (ex_op != dda_pkg::OP_NOP) begin
          d.flags = fl;
        end
        if (wacc) begin
          d.acc[ex_dst] = sm.r;
        end
        // Moves word-load the other accumulator (lower cleared), or read its limited upper word into opy
        if (hwdata[dda_pkg::CMD_PM_EN_BIT]) begin
          if (hwdata[dda_pkg::CMD_PM_DIR_BIT]) begin
            d.opy = lim16(ex_ov);
          end else begin
            d.acc[~ex_dst] = word_load(q.opx);
          end
        end
      end
    end else if (hsel && htrans[dda_pkg::HTRANS_ACT_BIT] && hready) begin
      d.pend = 1'b1;
      d.rdy = 1'b0;
      d.wr = hwrite;
      d.addr = haddr[dda_pkg::ADDR_W-1:0];
      d.hit = (hsize == dda_pkg::HSIZE_WORD) &&
              (haddr[31:dda_pkg::ADDR_W] == 24'h0);
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      q <= dda_pkg::ST_RST;
    end else begin
      q <= d;
    end
  end

  assign hreadyout = q.rdy;
  assign hrdata = q.rdata;
  assign hresp = q.resp;

  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);

  a_bus_wait: assert property (
    (hsel && htrans[1] && hready && !q.pend) |=>
      !hreadyout ##1 hreadyout)
    else $error("bus wait state wrong");
  a_add_same: assert property (
    (q.h_ex && q.h_op == dda_pkg::OP_ADD) |->
      q.acc[q.h_dst] == 36'(q.h_dv + hx_w))
    else $error("add result wrong");
  a_word_load: assert property (
    (q.pend && q.wr && q.hit && q.addr == dda_pkg::OFS_A_WORD) |=>
      q.acc[0] == word_load(q.acc[0][UH:UL]))
    else $error("word load not sign extended");
  a_logic_upper: assert property (
    (q.h_ex && q.h_op == dda_pkg::OP_EOR) |->
      q.acc[q.h_dst][UH:UL] == (q.h_dv[UH:UL] ^ q.h_x) &&
      q.acc[q.h_dst][LH:0] == q.h_dv[LH:0])
    else $error("xor not on upper word");
  a_asr_halve: assert property (
    (q.h_ex && q.h_op == dda_pkg::OP_ASR) |->
      q.acc[q.h_dst] == {q.h_dv[SB], q.h_dv[SB:1]})
    else $error("arith right shift wrong");
  a_frac_align: assert property (
    mi.x != 16'h4000 || mi.frac == {mi.y[LH], mi.y, 15'h0})
    else $error("fraction not one bit left");
  a_int_sign: assert property (
    (mi.intp != 32'h0) |-> mi.intp[UH] == (mi.x[LH] ^ mi.y[LH]))
    else $error("integer product sign wrong");
  a_round_clr: assert property (
    (q.h_ex && (q.h_op == dda_pkg::OP_ROUNDED_MULTIPLY ||
                q.h_op == dda_pkg::OP_ROUNDED_MULTIPLY_ACCUMULATE)) |->
      q.acc[q.h_dst][LH:0] == 16'h0)
    else $error("rounded lower word not clear");
  a_impy_place: assert property (
    (q.h_ex && q.h_op == dda_pkg::OP_IMPY) |->
      q.acc[q.h_dst][LH:0] == q.h_dv[LH:0] &&
      q.acc[q.h_dst][SB:EL] == {EW{q.acc[q.h_dst][UH]}})
    else $error("word multiply placement wrong");
  a_impy_ovf: assert property (
    (q.h_ex && q.h_op == dda_pkg::OP_IMPY) |->
      q.flags[dda_pkg::FL_L] == q.h_ovf)
    else $error("word multiply overflow flag wrong");
  a_ucmp_low: assert property (
    (q.h_ex && q.h_op == dda_pkg::OP_CMP && q.h_mode) |->
      cond[dda_pkg::CD_LO] == (q.h_dv[UH:0] < hx_w[UH:0]))
    else $error("unsigned compare carry wrong");
  a_limit_sat: assert property (
    (q.acc[0][SB:UH] != {(SB - UH + 1){q.acc[0][SB]}}) |->
      lim_a == (q.acc[0][SB] ? dda_pkg::WORD_NEG_MAX :
                               dda_pkg::WORD_POS_MAX))
    else $error("limited word wrong");

  c_mac_run: cover property (q.h_ex && q.h_op == dda_pkg::OP_MAC);
  c_mpy_asr: cover property ((q.h_ex && q.h_op == dda_pkg::OP_MPY)
    ##[1:40] (q.h_ex && q.h_op == dda_pkg::OP_ASR));
  c_ucmp: cover property (q.h_ex && q.h_op == dda_pkg::OP_CMP && q.h_mode);
  c_pmove: cover property (exec && hwdata[dda_pkg::CMD_PM_EN_BIT]);
endmodule : dda_alu

//--- bench/dda_issuer.sv
`timescale 1ns/10ps
module dda_issuer (
  input wire logic hclk, // Core clock
  output logic hsel, // Slave select
  output logic [31:0] haddr, // Byte address
  output logic [1:0] htrans, // Transfer type
  output logic hwrite, // Write strobe
  output logic [2:0] hsize, // Transfer size
  output logic [31:0] hwdata, // Write data
  input wire logic hready, // Bus ready
  input wire logic [31:0] hrdata // Read data
);
  logic ucmp_on;
  initial begin
    hsel = 1'b1;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = dda_pkg::HSIZE_WORD;
    hwdata = 32'h0;
    ucmp_on = 1'b0;
  end
  // Single word transfer, entered just after a rising edge
  task automatic xfer(input logic w, input logic [7:0] a,
                      input logic [31:0] wd, output logic [31:0] rd);
    htrans <= 2'h2;
    haddr <= {24'h0, a};
    hwrite <= w;
    do @(posedge hclk); while (hready !== 1'b1);
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge hclk); while (hready !== 1'b1);
    rd = hrdata;
    hwdata <= ~wd;
    if (w && a == dda_pkg::OFS_MODE) ucmp_on = wd[0];
  endtask : xfer
  task automatic cond_read(output logic [7:0] c);
    logic [31:0] r;
    xfer(1'b0, dda_pkg::OFS_COND, 32'h0, r);
    c = r[7:0];
    if (!ucmp_on) c[3:0] = 4'h0;
  endtask : cond_read
endmodule : dda_issuer

//--- bench/dda_alu_tb.sv
`timescale 1ns/10ps
module dda_alu_tb;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel, hwrite, hreadyout, hresp;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [31:0] haddr, hwdata, hrdata, r;
  logic [7:0] cv;
  int mismatches = 0;
  int checks_done = 0;
  logic [4:0] lop [5];
  logic [15:0] lexp [5];
  always #2 hclk = ~hclk;
  dda_issuer u_iss (.hclk(hclk), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hrdata(hrdata));
  dda_alu dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
    .hrdata(hrdata), .hresp(hresp));
  task automatic conclude();
    if (mismatches == 0 && checks_done > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : conclude
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      mismatches++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] x;
    u_iss.xfer(1'b1, a, d, x);
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [31:0] x);
    u_iss.xfer(1'b0, a, 32'h0, x);
    chk({31'h0, hresp}, 32'h0);
  endtask : rd
  task automatic ck(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] x;
    rd(a, x);
    chk(x, e);
  endtask : ck
  task automatic acc_a(input logic [31:0] e, u, l);
    ck(dda_pkg::OFS_A_EXT, e);
    ck(dda_pkg::OFS_A_UP, u);
    ck(dda_pkg::OFS_A_LO, l);
  endtask : acc_a
  task automatic la(input logic [31:0] e, u, l);
    wr(dda_pkg::OFS_A_EXT, e);
    wr(dda_pkg::OFS_A_UP, u);
    wr(dda_pkg::OFS_A_LO, l);
  endtask : la
  task automatic op(input logic [4:0] c, input logic [31:0] x, y);
    wr(dda_pkg::OFS_OPX, x);
    wr(dda_pkg::OFS_OPY, y);
    wr(dda_pkg::OFS_CMD, {27'h0, c});
  endtask : op
  initial begin
    #20000;
    mismatches++;
    conclude();
  end
  initial begin
    lop = '{dda_pkg::OP_AND, dda_pkg::OP_OR, dda_pkg::OP_EOR,
      dda_pkg::OP_BFCLR, dda_pkg::OP_NOT};
    lexp = '{16'h000F, 16'h0FFF, 16'h0FF0, 16'h0F00, 16'hF0F0};
    repeat (3) @(posedge hclk);
    hresetn <= 1'b1;
    acc_a(32'h0, 32'h0, 32'h0);
    wr(dda_pkg::OFS_A_LO, 32'h1234);
    wr(dda_pkg::OFS_A_WORD, 32'h8001);
    acc_a(32'hF, 32'h8001, 32'h0);
    // Borrow out of a word subtract
    wr(dda_pkg::OFS_MODE, 32'h1);
    wr(dda_pkg::OFS_A_WORD, 32'h1);
    op(dda_pkg::OP_SUB, 32'h2, 32'h0);
    acc_a(32'hF, 32'hFFFF, 32'h0);
    ck(dda_pkg::OFS_FLAGS, 32'h09);
    u_iss.cond_read(cv);
    chk({24'h0, cv}, 32'hAA);
    for (int m = 0; m < 2; m++) begin
      wr(dda_pkg::OFS_MODE, m);
      la(32'h1, 32'h0, 32'h0);
      op(dda_pkg::OP_CMP, 32'h0, 32'h0);
      ck(dda_pkg::OFS_FLAGS, m ? 32'h04 : 32'h00);
      ck(dda_pkg::OFS_A_EXT, 32'h1);
    end
    wr(dda_pkg::OFS_A_WORD, 32'h4000);
    op(dda_pkg::OP_ASL, 32'h0, 32'h0);
    acc_a(32'h0, 32'h8000, 32'h0);
    op(dda_pkg::OP_ASR, 32'h0, 32'h0);
    acc_a(32'h0, 32'h4000, 32'h0);
    wr(dda_pkg::OFS_A_WORD, 32'h8000);
    op(dda_pkg::OP_ASR, 32'h0, 32'h0);
    acc_a(32'hF, 32'hC000, 32'h0);
    la(32'h0, 32'h8001, 32'h5555);
    op(dda_pkg::OP_LSR, 32'h0, 32'h0);
    acc_a(32'h0, 32'h4000, 32'h5555);
    la(32'h0, 32'hFFFF, 32'h1234);
    op(dda_pkg::OP_WORD_INCREMENT, 32'h0, 32'h0);
    acc_a(32'h1, 32'h0, 32'h1234);
    for (int i = 0; i < 5; i++) begin
      wr(dda_pkg::OFS_A_WORD, 32'h0F0F);
      op(lop[i], 32'h00FF, 32'h0);
      ck(dda_pkg::OFS_A_UP, {16'h0, lexp[i]});
    end
    op(dda_pkg::OP_MPY, 32'hFFFD, 32'h5);
    acc_a(32'hF, 32'hFFFF, 32'hFFE2);
    op(dda_pkg::OP_ASR, 32'h0, 32'h0);
    acc_a(32'hF, 32'hFFFF, 32'hFFF1);
    op(dda_pkg::OP_MAC, 32'h3, 32'h5);
    acc_a(32'h0, 32'h0, 32'h000F);
    op(dda_pkg::OP_ROUNDED_MULTIPLY, 32'h4000, 32'h1);
    acc_a(32'h0, 32'h1, 32'h0);
    op(dda_pkg::OP_ROUNDED_MULTIPLY_ACCUMULATE, 32'h4000, 32'h1);
    acc_a(32'h0, 32'h2, 32'h0);
    wr(dda_pkg::OFS_A_LO, 32'h1234);
    op(dda_pkg::OP_IMPY, 32'hFFFD, 32'h5);
    acc_a(32'hF, 32'hFFF1, 32'h1234);
    rd(dda_pkg::OFS_FLAGS, r);
    chk({31'h0, r[4]}, 32'h0);
    op(dda_pkg::OP_IMPY, 32'h4000, 32'h4);
    rd(dda_pkg::OFS_FLAGS, r);
    chk({31'h0, r[4]}, 32'h1);
    wr(dda_pkg::OFS_MODE, 32'h0);
    wr(dda_pkg::OFS_A_WORD, 32'h7FFF);
    op(dda_pkg::OP_ADD, 32'h1, 32'h0);
    acc_a(32'h0, 32'h8000, 32'h0);
    ck(dda_pkg::OFS_FLAGS, 32'h10);
    wr(dda_pkg::OFS_B_WORD, 32'h3);
    wr(dda_pkg::OFS_CMD, 32'h0104);
    ck(dda_pkg::OFS_B_UP, 32'h8003);
    wr(dda_pkg::OFS_CMD, 32'h0005);
    acc_a(32'hF, 32'hFFFD, 32'h0);
    ck(dda_pkg::OFS_FLAGS, 32'h19);
    la(32'h0, 32'h8001, 32'h0);
    op(dda_pkg::OP_LSL, 32'h0, 32'h0);
    ck(dda_pkg::OFS_A_UP, 32'h0002);
    op(dda_pkg::OP_ROR, 32'h0, 32'h0);
    ck(dda_pkg::OFS_A_UP, 32'h8001);
    op(dda_pkg::OP_ROL, 32'h0, 32'h0);
    ck(dda_pkg::OFS_A_UP, 32'h0002);
    op(dda_pkg::OP_WORD_DECREMENT, 32'h0, 32'h0);
    ck(dda_pkg::OFS_A_UP, 32'h0001);
    op(dda_pkg::OP_DIV, 32'h1, 32'h0);
    acc_a(32'h0, 32'h0001, 32'h0);
    ck(dda_pkg::OFS_FLAGS, 32'h11);
    // Parallel moves through the other accumulator
    wr(dda_pkg::OFS_OPX, 32'h8002);
    wr(dda_pkg::OFS_CMD, 32'h1000);
    ck(dda_pkg::OFS_B_UP, 32'h8002);
    ck(dda_pkg::OFS_B_LO, 32'h0);
    wr(dda_pkg::OFS_CMD, 32'h3000);
    ck(dda_pkg::OFS_OPY, 32'h8002);
    wr(dda_pkg::OFS_B_EXT, 32'h1);
    ck(dda_pkg::OFS_B_LIM, 32'h7FFF);
    wr(dda_pkg::OFS_B_EXT, 32'hE);
    wr(dda_pkg::OFS_CMD, 32'h3000);
    ck(dda_pkg::OFS_OPY, 32'h8000);
    wr(8'h40, 32'hFFFF);
    ck(8'h40, 32'h0);
    ck(dda_pkg::OFS_CMD, 32'h0);
    conclude();
  end
endmodule : dda_alu_tb
